/* File: hdl/irq_bank_pkg.sv */
// How it works
// - first enable register bits 6..0 enable adc, collision, serial, capcmp2, capcmp1, timer2, timer1.
// - second enable bits 7,4,3,2,1,0 enable desaturation, overtemp, overvolt, gate drive undervolt, input_overvolt_lockout, input_undervolt_lockout.
// - unimplemented bits read zero; implemented bits read, write, reset to zero, except status bits, which clear on read and ignore writes.
// - no peripheral request reaches the core unless the peripheral gate bit is set.
// - each flag sets on its event regardless of its enable or global enable.
// - adc flag bit 6 sets when a conversion completes and holds until firmware clears it.
// - flag bit 5 marks pending collision, bit 4 marks pending serial port interrupt.
// - flag bits 3 and 2 set on capture or compare in unit 2, unit 1.
// - flag bit 1 sets on timer2 period match and holds until firmware clears it.
// - flag bit 0 sets on timer1 rollover and holds until firmware clears it.
// - second flag register holds active-low desaturation bit 7 and bits 4..0 faults.
// - core is redirected only while global enable is set; cleared on reset and service entry.
package irq_bank_pkg;
  localparam int          DATA_W          = 8;
  localparam int          ADDR_W          = 4;
  // register offsets
  localparam logic [3:0]  ADDR_ENABLE_ONE = 4'h0;
  localparam logic [3:0]  ADDR_ENABLE_TWO = 4'h1;
  localparam logic [3:0]  ADDR_FLAGS_ONE  = 4'h2;
  localparam logic [3:0]  ADDR_FLAGS_TWO  = 4'h3;
  localparam logic [3:0]  ADDR_CORE_CTRL  = 4'h4;
  localparam logic [3:0]  ADDR_IRQ_STATUS = 4'h5;
  localparam logic [3:0]  ADDR_IRQ_MASK   = 4'h6;
  // implemented bit masks
  localparam logic [7:0]  IMPL_ONE        = 8'h7F;
  localparam logic [7:0]  IMPL_TWO        = 8'h9F;
  localparam logic [7:0]  IMPL_CORE       = 8'hC0;
  localparam logic [7:0]  IMPL_STATUS     = 8'h07;
  // active-low flag bits of the first and second flag registers
  localparam logic [7:0]  LOW_ONE         = 8'h00;
  localparam logic [7:0]  LOW_TWO         = 8'h80;
  // reset values
  localparam logic [7:0]  RST_ENABLE      = 8'h00;
  localparam logic [7:0]  RST_FLAGS       = 8'h00;
  localparam logic [7:0]  RST_CORE        = 8'h00;
  localparam logic [7:0]  RST_STATUS      = 8'h00;
  localparam logic [7:0]  RST_MASK        = 8'h00;
  // first register field positions
  localparam int          BIT_ADC         = 6;
  localparam int          BIT_COLLISION   = 5;
  localparam int          BIT_SERIAL      = 4;
  localparam int          BIT_CAPCMP_TWO  = 3;
  localparam int          BIT_CAPCMP_ONE  = 2;
  localparam int          BIT_TIMER_TWO   = 1;
  localparam int          BIT_TIMER_ONE   = 0;
  // second register field positions
  localparam int          BIT_SWITCH_DESATURATION       = 7;
  localparam int          BIT_OVERTEMP    = 4;
  localparam int          BIT_OUT_OV      = 3;
  localparam int          BIT_DRIVE_UV    = 2;
  localparam int          BIT_IN_INPUT_OVERVOLT_LOCKOUT     = 1;
  localparam int          BIT_IN_INPUT_UNDERVOLT_LOCKOUT     = 0;
  // core control field positions
  localparam int          BIT_GLOBAL      = 7;
  localparam int          BIT_GATE        = 6;
  // interrupt status field positions
  localparam int          ST_FLAGS_ONE    = 0;
  localparam int          ST_FLAGS_TWO    = 1;
  localparam int          ST_REDIRECT     = 2;
endpackage

/* File: hdl/sticky_flag_bank.sv */
`timescale 1ns/10ps
`default_nettype none
module sticky_flag_bank
#(
  parameter int         W      = 8,
  parameter logic [7:0] IMPL   = 8'hFF,
  parameter logic [7:0] LOW    = 8'h00,
  parameter logic [7:0] RST    = 8'h00
)
(
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // firmware write
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_val,
  // hardware events
  input  wire logic [W-1:0] evt,
  // flag state
  output logic      [W-1:0] flags_reg
);
  logic [W-1:0] base;
  logic [W-1:0] flags_next;

  always_comb
  begin
    base       = wr_en ? wr_val : flags_reg;
    // events applied after the write
    flags_next = (base | (evt & ~LOW[W-1:0])) & ~(evt & LOW[W-1:0]);
    flags_next = flags_next & IMPL[W-1:0];
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      flags_reg <= RST[W-1:0];
    else
      flags_reg <= flags_next;
  end
endmodule // sticky_flag_bank
`default_nettype wire

/* File: hdl/request_combiner.sv */
`timescale 1ns/10ps
`default_nettype none
module request_combiner
#(
  parameter int         W   = 8,
  parameter logic [7:0] LOW = 8'h00
)
(
  // flag and enable pairs
  input  wire logic [W-1:0] flags_one,
  input  wire logic [W-1:0] enable_one,
  input  wire logic [W-1:0] flags_two,
  input  wire logic [W-1:0] enable_two,
  // gate
  input  wire logic         gate,
  // request
  output logic              request
);
  logic [W-1:0] active_two;

  // desaturation flag is active low
  assign active_two = flags_two ^ LOW[W-1:0];
  assign request    = gate & (|(flags_one & enable_one) | |(active_two & enable_two));
endmodule // request_combiner
`default_nettype wire

/* File: hdl/peripheral_irq_enable_flag_bank.sv */
`timescale 1ns/10ps
`default_nettype none
module peripheral_irq_enable_flag_bank
(
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  // register port
  input  wire logic [irq_bank_pkg::ADDR_W-1:0] addr,
  input  wire logic [irq_bank_pkg::DATA_W-1:0] wr_data,
  input  wire logic                          wr_stb,
  input  wire logic                          rd_stb,
  output logic      [irq_bank_pkg::DATA_W-1:0] rd_data,
  // first group of peripheral events
  input  wire logic                          adc_done_evt,
  input  wire logic                          serial_collision_evt,
  input  wire logic                          serial_port_evt,
  input  wire logic                          capcmp_two_evt,
  input  wire logic                          capcmp_one_evt,
  input  wire logic                          timer_two_match_evt,
  input  wire logic                          timer_one_wrap_evt,
  // second group of peripheral events
  input  wire logic                          desaturation_evt,
  input  wire logic                          overtemp_evt,
  input  wire logic                          output_overvolt_evt,
  input  wire logic                          gate_drive_undervolt_evt,
  input  wire logic                          input_overvolt_lock_evt,
  input  wire logic                          input_undervolt_lock_evt,
  // core service handshake
  input  wire logic                          isr_enter,
  input  wire logic                          isr_return,
  // requests to the core
  output logic                               peripheral_request,
  output logic                               core_redirect,
  // interrupt line
  output logic                               irq
);
  import irq_bank_pkg::*;

  logic [7:0] enable_one_reg;
  logic [7:0] enable_two_reg;
  logic [7:0] flags_one_reg;
  logic [7:0] flags_two_reg;
  logic [7:0] core_ctrl_reg;
  logic [7:0] irq_status_reg;
  logic [7:0] irq_mask_reg;
  logic [7:0] core_ctrl_next;
  logic [7:0] irq_status_next;
  logic [7:0] rd_next;
  logic [7:0] evt_one;
  logic [7:0] evt_two;
  logic [7:0] status_evt;
  logic       wr_enable_one;
  logic       wr_enable_two;
  logic       wr_flags_one;
  logic       wr_flags_two;
  logic       wr_core;
  logic       wr_mask;
  logic       rd_status;
  logic       request_raw;
  logic       redirect_prev_reg;
  logic       global_enable;
  logic       gate_enable;

  // address decode
  assign wr_enable_one = wr_stb & (addr == ADDR_ENABLE_ONE);
  assign wr_enable_two = wr_stb & (addr == ADDR_ENABLE_TWO);
  assign wr_flags_one  = wr_stb & (addr == ADDR_FLAGS_ONE);
  assign wr_flags_two  = wr_stb & (addr == ADDR_FLAGS_TWO);
  assign wr_core       = wr_stb & (addr == ADDR_CORE_CTRL);
  assign wr_mask       = wr_stb & (addr == ADDR_IRQ_MASK);
  assign rd_status     = rd_stb & (addr == ADDR_IRQ_STATUS);

  // first event vector
  always_comb
  begin
    evt_one                 = 8'h00;
    evt_one[BIT_ADC]        = adc_done_evt;
    evt_one[BIT_COLLISION]  = serial_collision_evt;
    evt_one[BIT_SERIAL]     = serial_port_evt;
    evt_one[BIT_CAPCMP_TWO] = capcmp_two_evt;
    evt_one[BIT_CAPCMP_ONE] = capcmp_one_evt;
    evt_one[BIT_TIMER_TWO]  = timer_two_match_evt;
    evt_one[BIT_TIMER_ONE]  = timer_one_wrap_evt;
  end

  // second event vector
  always_comb
  begin
    evt_two               = 8'h00;
    evt_two[BIT_SWITCH_DESATURATION]    = desaturation_evt;
    evt_two[BIT_OVERTEMP] = overtemp_evt;
    evt_two[BIT_OUT_OV]   = output_overvolt_evt;
    evt_two[BIT_DRIVE_UV] = gate_drive_undervolt_evt;
    evt_two[BIT_IN_INPUT_OVERVOLT_LOCKOUT]  = input_overvolt_lock_evt;
    evt_two[BIT_IN_INPUT_UNDERVOLT_LOCKOUT]  = input_undervolt_lock_evt;
  end

  // first enable register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      enable_one_reg <= RST_ENABLE;
    else if (wr_enable_one)
      enable_one_reg <= wr_data & IMPL_ONE;
  end

  // second enable register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      enable_two_reg <= RST_ENABLE;
    else if (wr_enable_two)
      enable_two_reg <= wr_data & IMPL_TWO;
  end

  // first flag register
  sticky_flag_bank
  #(
    .W    (8),
    .IMPL (IMPL_ONE),
    .LOW  (LOW_ONE),
    .RST  (RST_FLAGS)
  )
  u_flags_one
  (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .wr_en     (wr_flags_one),
    .wr_val    (wr_data),
    .evt       (evt_one),
    .flags_reg (flags_one_reg)
  );

  // second flag register, desaturation bit active low
  sticky_flag_bank
  #(
    .W    (8),
    .IMPL (IMPL_TWO),
    .LOW  (LOW_TWO),
    .RST  (RST_FLAGS)
  )
  u_flags_two
  (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .wr_en     (wr_flags_two),
    .wr_val    (wr_data),
    .evt       (evt_two),
    .flags_reg (flags_two_reg)
  );

  // core control: global enable and peripheral gate
  always_comb
  begin
    core_ctrl_next = core_ctrl_reg;
    if (wr_core)
      core_ctrl_next = wr_data & IMPL_CORE;
    if (isr_return)
      core_ctrl_next[BIT_GLOBAL] = 1'b1;
    // service entry always drops the global enable
    if (isr_enter)
      core_ctrl_next[BIT_GLOBAL] = 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      core_ctrl_reg <= RST_CORE;
    else
      core_ctrl_reg <= core_ctrl_next;
  end

  assign global_enable = core_ctrl_reg[BIT_GLOBAL];
  assign gate_enable   = core_ctrl_reg[BIT_GATE];

  // request to the core
  request_combiner
  #(
    .W   (8),
    .LOW (LOW_TWO)
  )
  u_request
  (
    .flags_one  (flags_one_reg),
    .enable_one (enable_one_reg),
    .flags_two  (flags_two_reg),
    .enable_two (enable_two_reg),
    .gate       (gate_enable),
    .request    (request_raw)
  );

  assign peripheral_request = request_raw;
  assign core_redirect      = request_raw & global_enable;

  // redirect edge tracking
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      redirect_prev_reg <= 1'b0;
    else
      redirect_prev_reg <= core_redirect;
  end

  // status events
  always_comb
  begin
    status_evt               = 8'h00;
    status_evt[ST_FLAGS_ONE] = |evt_one;
    status_evt[ST_FLAGS_TWO] = |evt_two;
    status_evt[ST_REDIRECT]  = core_redirect & ~redirect_prev_reg;
  end

  // sticky status, cleared by read, event wins
  always_comb
  begin
    irq_status_next = rd_status ? 8'h00 : irq_status_reg;
    irq_status_next = (irq_status_next | status_evt) & IMPL_STATUS;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      irq_status_reg <= RST_STATUS;
    else
      irq_status_reg <= irq_status_next;
  end

  // status mask
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      irq_mask_reg <= RST_MASK;
    else if (wr_mask)
      irq_mask_reg <= wr_data & IMPL_STATUS;
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // read mux
  always_comb
  begin
    rd_next = 8'h00;
    if (rd_stb)
    begin
      unique case (addr)
        ADDR_ENABLE_ONE: rd_next = enable_one_reg;
        ADDR_ENABLE_TWO: rd_next = enable_two_reg;
        ADDR_FLAGS_ONE:  rd_next = flags_one_reg;
        ADDR_FLAGS_TWO:  rd_next = flags_two_reg;
        ADDR_CORE_CTRL:  rd_next = core_ctrl_reg;
        ADDR_IRQ_STATUS: rd_next = irq_status_reg;
        ADDR_IRQ_MASK:   rd_next = irq_mask_reg;
        default:         rd_next = 8'h00;
      endcase
    end
  end

  // read data stands one cycle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rd_data <= 8'h00;
    else
      rd_data <= rd_next;
  end
endmodule // peripheral_irq_enable_flag_bank
`default_nettype wire

/* File: testbench/irq_bank_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module irq_bank_asserts
  import irq_bank_pkg::*;
(
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  // register port
  input  wire logic [irq_bank_pkg::ADDR_W-1:0] addr,
  input  wire logic [irq_bank_pkg::DATA_W-1:0] wr_data,
  input  wire logic                          wr_stb,
  input  wire logic                          rd_stb,
  input  wire logic [irq_bank_pkg::DATA_W-1:0] rd_data,
  // events
  input  wire logic                          adc_done_evt,
  input  wire logic                          timer_two_match_evt,
  input  wire logic                          timer_one_wrap_evt,
  // core side
  input  wire logic                          isr_enter,
  input  wire logic                          isr_return,
  input  wire logic                          peripheral_request,
  input  wire logic                          core_redirect
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  property p_rd_idle;
    !$past(rd_stb) |-> rd_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read cycle");
  property p_en_one;
    ((wr_stb && addr == ADDR_ENABLE_ONE) ##1 (rd_stb && addr == ADDR_ENABLE_ONE))
      |=> rd_data == ($past(wr_data, 2) & IMPL_ONE);
  endproperty
  a_en_one: assert property (p_en_one)
    else $error("first enable readback wrong");
  property p_en_two;
    ((wr_stb && addr == ADDR_ENABLE_TWO) ##1 (rd_stb && addr == ADDR_ENABLE_TWO))
      |=> rd_data == ($past(wr_data, 2) & IMPL_TWO);
  endproperty
  a_en_two: assert property (p_en_two)
    else $error("second enable readback wrong");
  property p_unimpl;
    $past(rd_stb) && $past(addr) == ADDR_ENABLE_TWO |-> rd_data[6:5] == 2'b00;
  endproperty
  a_unimpl: assert property (p_unimpl)
    else $error("unimplemented bits not zero");
  property p_unmapped;
    $past(rd_stb) && $past(addr) > ADDR_IRQ_MASK |-> rd_data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_adc;
    (adc_done_evt ##1 (rd_stb && addr == ADDR_FLAGS_ONE)) |=> rd_data[6];
  endproperty
  a_adc: assert property (p_adc)
    else $error("conversion flag not set");
  property p_tmr2;
    (timer_two_match_evt ##1 (rd_stb && addr == ADDR_FLAGS_ONE)) |=> rd_data[1];
  endproperty
  a_tmr2: assert property (p_tmr2)
    else $error("period match flag not set");
  property p_tmr1;
    (timer_one_wrap_evt ##1 (rd_stb && addr == ADDR_FLAGS_ONE)) |=> rd_data[0];
  endproperty
  a_tmr1: assert property (p_tmr1)
    else $error("rollover flag not set");
  property p_redirect;
    core_redirect |-> peripheral_request;
  endproperty
  a_redirect: assert property (p_redirect)
    else $error("redirect without request");
  property p_isr;
    isr_enter |=> !core_redirect;
  endproperty
  a_isr: assert property (p_isr)
    else $error("redirect after service entry");
  property p_return;
    isr_return && !isr_enter && !wr_stb |=> core_redirect == peripheral_request;
  endproperty
  a_return: assert property (p_return)
    else $error("global enable not restored on return");
  property p_gate_off;
    wr_stb && addr == ADDR_CORE_CTRL && !wr_data[BIT_GATE] |=> !peripheral_request;
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("request without peripheral gate");
endmodule // irq_bank_asserts
bind peripheral_irq_enable_flag_bank irq_bank_asserts u_asserts (.clk_sys, .rst, .addr, .wr_data, .wr_stb,
  .rd_stb, .rd_data, .adc_done_evt, .timer_two_match_evt, .timer_one_wrap_evt, .isr_enter, .isr_return,
  .peripheral_request, .core_redirect);
`default_nettype wire

/* File: testbench/core_event_model.sv */
`timescale 1ns/10ps
`default_nettype none
module core_event_model
(
  // clock
  input  wire logic        clk_sys,
  // core side
  input  wire logic        core_redirect,
  output logic             isr_enter,
  output logic             isr_return,
  // event sources
  output logic [12:0]      evt
);
  initial
  begin
    isr_enter = 1'b0;
    isr_return = 1'b0;
    evt = 13'h0000;
  end
  // core enters service one cycle after being redirected
  always @(posedge clk_sys)
    isr_enter <= core_redirect && !isr_enter;
  task automatic fire(input logic [12:0] m);
    evt <= m;
    @(posedge clk_sys);
    evt <= 13'h0000;
    #1;
  endtask
  task automatic leave;
    isr_return <= 1'b1;
    @(posedge clk_sys);
    isr_return <= 1'b0;
    #1;
  endtask
endmodule // core_event_model
`default_nettype wire

/* File: testbench/tb_peripheral_irq_enable_flag_bank.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_peripheral_irq_enable_flag_bank;
  import irq_bank_pkg::*;
  typedef struct {logic [3:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wr_data = 8'h00;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic [7:0]  rd_data;
  logic [12:0] evt;
  logic        isr_enter, isr_return, peripheral_request, core_redirect, irq;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cyc = 0;
  row_t        rows [12] = '{'{ADDR_ENABLE_ONE, 8'hFF, 8'h7F}, '{ADDR_ENABLE_TWO, 8'hFF, 8'h9F},
    '{ADDR_FLAGS_ONE, 8'hFF, 8'h7F}, '{ADDR_FLAGS_TWO, 8'hFF, 8'h9F}, '{ADDR_CORE_CTRL, 8'h00, 8'h00},
    '{ADDR_IRQ_MASK, 8'hFF, 8'h07}, '{4'h7, 8'hFF, 8'h00}, '{4'hF, 8'h5A, 8'h00},
    '{ADDR_ENABLE_ONE, 8'h00, 8'h00}, '{ADDR_ENABLE_TWO, 8'h00, 8'h00},
    '{ADDR_FLAGS_ONE, 8'h00, 8'h00}, '{ADDR_IRQ_MASK, 8'h00, 8'h00}};

  always #25 clk_sys = ~clk_sys;

  peripheral_irq_enable_flag_bank dut (.clk_sys, .rst, .addr, .wr_data, .wr_stb, .rd_stb, .rd_data,
    .adc_done_evt(evt[6]), .serial_collision_evt(evt[5]), .serial_port_evt(evt[4]),
    .capcmp_two_evt(evt[3]), .capcmp_one_evt(evt[2]), .timer_two_match_evt(evt[1]),
    .timer_one_wrap_evt(evt[0]), .desaturation_evt(evt[12]), .overtemp_evt(evt[11]),
    .output_overvolt_evt(evt[10]), .gate_drive_undervolt_evt(evt[9]), .input_overvolt_lock_evt(evt[8]),
    .input_undervolt_lock_evt(evt[7]), .isr_enter, .isr_return, .peripheral_request, .core_redirect, .irq);
  core_event_model u_far (.clk_sys, .core_redirect, .isr_enter, .isr_return, .evt);

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input bit ck = 1'b1);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1;
    if (ck)
      chk(rd_data, e);
  endtask
  task automatic end_sim;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      end_sim();
    end
  end

  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    for (int i = 0; i < 7; i++)
      rd(4'(i), 8'h00);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    for (int i = 0; i < 7; i++)
    begin
      wr(ADDR_FLAGS_ONE, 8'h00);
      u_far.fire(13'(1 << i));
      rd(ADDR_FLAGS_ONE, 8'(1 << i));
      rd(ADDR_FLAGS_ONE, 8'(1 << i));
    end
    for (int j = 0; j < 6; j++)
    begin
      wr(ADDR_FLAGS_TWO, 8'h80);
      u_far.fire(13'(1 << (7 + j)));
      rd(ADDR_FLAGS_TWO, (j == 5) ? 8'h00 : (8'h80 | 8'(1 << j)));
    end
    fork
      u_far.fire(13'h0001);
      wr(ADDR_FLAGS_ONE, 8'h00);
    join
    rd(ADDR_FLAGS_ONE, 8'h01);
    wr(ADDR_ENABLE_TWO, 8'h80);
    chk({7'h00, peripheral_request}, 8'h00);
    wr(ADDR_CORE_CTRL, 8'h40);
    chk({7'h00, peripheral_request}, 8'h01);
    chk({7'h00, core_redirect}, 8'h00);
    wr(ADDR_FLAGS_TWO, 8'h80);
    chk({7'h00, peripheral_request}, 8'h00);
    wr(ADDR_FLAGS_ONE, 8'h00);
    wr(ADDR_ENABLE_ONE, 8'h01);
    chk({7'h00, peripheral_request}, 8'h00);
    u_far.fire(13'h0001);
    chk({7'h00, peripheral_request}, 8'h01);
    wr(ADDR_CORE_CTRL, 8'hC0);
    chk({7'h00, core_redirect}, 8'h01);
    repeat (3) @(posedge clk_sys);
    #1;
    chk({7'h00, core_redirect}, 8'h00);
    u_far.leave();
    chk({7'h00, core_redirect}, 8'h01);
    wr(ADDR_CORE_CTRL, 8'h00);
    wr(ADDR_FLAGS_ONE, 8'h00);
    rd(ADDR_IRQ_STATUS, 8'h07);
    wr(ADDR_IRQ_MASK, 8'h01);
    chk({7'h00, irq}, 8'h00);
    u_far.fire(13'h0002);
    @(posedge clk_sys);
    #1;
    chk({7'h00, irq}, 8'h01);
    rd(ADDR_IRQ_STATUS, 8'h01);
    chk({7'h00, irq}, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h00);
    u_far.fire(13'h0002);
    @(posedge clk_sys);
    #1;
    chk({7'h00, irq}, 8'h00);
    rd(ADDR_IRQ_STATUS, 8'h01);
    // event beats the read clear of status
    fork
      u_far.fire(13'h0002);
      rd(ADDR_IRQ_STATUS, 8'h00);
    join
    rd(ADDR_IRQ_STATUS, 8'h01);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    rd(ADDR_ENABLE_ONE, 8'h00);
    end_sim();
  end
endmodule // tb_peripheral_irq_enable_flag_bank
`default_nettype wire
